// ==== src/aimps_top.sv ====
// Mode and pin-function selection front end with sample capture.
// Assumes every pin is asynchronous; mode fields come from local logic.
`timescale 1ns/1ps
module aimps_top
  import aimps_pkg::*;
#(
  parameter int SW = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Mode and address pins.
  input wire logic power_down_n_in,
  input wire logic control_style_select_in,
  input wire logic i2c_select_in,
  input wire logic clock_setting_select_in,
  input wire logic chip_addr_bit0_in,
  // Shared audio pins.
  input wire logic shared_clock_in,
  input wire logic [LANES-1:0] shared_data_in,
  input wire logic word_clock_in,
  input wire logic [ALT_N-1:0] alt_group_in,
  input wire logic mclk_in,
  // Control port pins.
  input wire logic ctrl_select_n_in,
  input wire logic ctrl_clock_in,
  input wire logic ctrl_data_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_n_out,
  // Register fields from the control logic.
  input wire logic [1:0] input_mode_sel_in,
  input wire logic stream_path_select_in,
  input wire logic [FIELD_W-1:0] stream_mclk_freq_field_in,
  input wire logic chain_enable_in,
  input wire logic sda_pull_low_in,
  // Decoded configuration.
  output logic reg_control_out,
  output logic use_i2c_out,
  output logic [1:0] chip_addr_out,
  output logic auto_clock_out,
  output logic filter_select_c_out,
  output logic deemph_enable_out,
  output logic [1:0] frame_mode_out,
  output logic chain_mode_out,
  output logic right_invert_out,
  output logic [1:0] input_mode_out,
  // Control port towards the register file.
  output logic ctrl_port_select_n_out,
  output logic ctrl_port_clock_out,
  output logic ctrl_port_data_out,
  output logic i2c_scl_out,
  output logic i2c_data_out,
  // Clock supervision and status.
  output logic mclk_absent_out,
  output logic [RATIO_W-1:0] mclk_div_out,
  output logic overrun_out,
  output logic chain_serial_out,
  // Sample stream.
  output logic sample_valid_out,
  output logic [TAG_W+SW-1:0] sample_data_out,
  input wire logic sample_ready_in
);
  localparam int CNT_W = $clog2(SW);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(SW - 1);
  localparam logic [IDLE_W-1:0] STOP_CYC = IDLE_W'(MCLK_STOP_CYC);
  localparam logic [LOCK_W-1:0] LOCK_CNT = LOCK_W'(LOCK_EDGES);

  typedef struct packed {
    logic reg_mode;
    logic use_i2c;
    logic [1:0] chip_addr;
    logic auto_clk;
    logic filt_c;
    logic deemph;
    logic [1:0] frame_mode;
    logic chain_mode;
    logic inv_r;
    logic ctl_sel_n;
    logic ctl_clk;
    logic ctl_dat;
    logic scl;
    logic sda_i;
    logic sda_o;
    logic sda_oe_n;
    aimps_mode_t mode;
    logic bclk_prev;
    logic fclk_prev;
    logic [LANES-1:0][SW-1:0] shf;
    logic [LANES-1:0][SW-1:0] hold;
    logic [LANES-1:0] pend;
    logic side;
    logic [CNT_W-1:0] bitcnt;
    logic [SW-1:0] chain;
    logic chain_o;
    logic mclk_prev;
    logic [IDLE_W-1:0] idle;
    logic [RATIO_W-1:0] mcnt;
    logic [RATIO_W-1:0] ratio;
    logic [RATIO_W-1:0] div;
    logic [LOCK_W-1:0] lockc;
    aimps_mc_t mc;
    logic absent;
    logic overrun;
  } aimps_top_t;

  aimps_top_t s_q;
  aimps_top_t s_d;
  logic [NSYNC-1:0] sy;
  logic run_rst;
  logic reg_m;
  logic i2c_m;
  logic wire3_m;
  logic alt_path;
  logic bclk;
  logic fclk;
  logic [LANES-1:0] lane_bit;
  logic bit_rise;
  logic bit_fall;
  logic frame_edge;
  logic mclk_rise;
  logic running;
  logic [LANE_W-1:0] lane_sel;
  logic fifo_valid;
  logic fifo_ready;
  logic [TAG_W+SW-1:0] fifo_data;

  // Rising edge of a sampled level.
  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // Lowest pending lane, so lanes leave in a fixed order.
  function automatic logic [LANE_W-1:0] first_lane(
    input logic [LANES-1:0] p
  );
    logic [LANE_W-1:0] r;
    r = '0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = LANE_W'(i);
      end
    end
    return r;
  endfunction

  // Decode the requested input mode, unknown codes fall back to PCM.
  function automatic aimps_mode_t pick_mode(input logic [1:0] code);
    case (code)
      AIMPS_ONEBIT: return AIMPS_ONEBIT;
      AIMPS_EXF: return AIMPS_EXF;
      default: return AIMPS_PCM;
    endcase
  endfunction

  // Every pin passes two flip-flops before any logic reads it.
  aimps_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({i2c_sda_in, ctrl_data_in, ctrl_clock_in, ctrl_select_n_in,
               mclk_in, alt_group_in, word_clock_in, shared_data_in,
               shared_clock_in, chip_addr_bit0_in, clock_setting_select_in,
               i2c_select_in, control_style_select_in, power_down_n_in}),
    .sync_out(sy)
  );

  // Power-down holds everything behind the synchroniser in reset.
  assign run_rst = rst_in | ~sy[SY_PDN];

  // Pin decoding, clock supervision and sample capture.
  always_comb begin
    s_d = s_q;
    reg_m = ~sy[SY_PSN];
    i2c_m = reg_m & sy[SY_I2C];
    wire3_m = reg_m & ~sy[SY_I2C];
    alt_path = (s_q.mode == AIMPS_ONEBIT) & ~stream_path_select_in;
    bclk = alt_path ? sy[SY_ALT+ALT_CLK] : sy[SY_P43];
    fclk = (s_q.mode == AIMPS_PCM) ? sy[SY_DAT+1] : sy[SY_P48];
    lane_bit = alt_path ? {sy[SY_ALT+ALT_CHAIN], sy[SY_ALT+ALT_FRM1],
                           sy[SY_ALT+ALT_INV], sy[SY_ALT+ALT_DEEMPH]}
                        : sy[SY_DAT+:LANES];
    if (s_q.mode == AIMPS_PCM) begin
      lane_bit = {2'h0, sy[SY_DAT+2], sy[SY_DAT]};
    end
    bit_rise = rose(s_q.bclk_prev, bclk);
    bit_fall = rose(bclk, s_q.bclk_prev);
    mclk_rise = rose(s_q.mclk_prev, sy[SY_MCLK]);
    running = (s_q.mc == MC_RUN);
    lane_sel = first_lane(s_q.pend);
    frame_edge = 1'b0;

    // Control style, interface and address decoding.
    s_d.reg_mode = reg_m;
    s_d.use_i2c = i2c_m;
    s_d.chip_addr = reg_m ? {sy[SY_CLOCK_SETTING_SELECT], sy[SY_CHIP_ADDR_BIT0]} : 2'h0;
    s_d.auto_clk = ~reg_m & sy[SY_CLOCK_SETTING_SELECT];
    s_d.mode = reg_m ? pick_mode(input_mode_sel_in) : AIMPS_PCM;

    // Configuration pins are only meaningful under pin control.
    if (reg_m) begin
      s_d.filt_c = 1'b0;
      s_d.deemph = 1'b0;
      s_d.frame_mode = 2'h0;
      s_d.chain_mode = chain_enable_in;
      s_d.inv_r = 1'b0;
    end else begin
      s_d.filt_c = sy[SY_P48];
      s_d.deemph = sy[SY_ALT+ALT_DEEMPH];
      s_d.frame_mode = {sy[SY_ALT+ALT_FRM1], sy[SY_ALT+ALT_CLK]};
      s_d.chain_mode = sy[SY_ALT+ALT_CHAIN];
      s_d.inv_r = sy[SY_ALT+ALT_INV];
    end

    // Route the control pins to whichever port is selected.
    s_d.ctl_sel_n = ~wire3_m | sy[SY_CSN];
    s_d.ctl_clk = wire3_m & sy[SY_CTRL_CLOCK];
    s_d.ctl_dat = wire3_m & sy[SY_CTRL_DATA_IN];
    s_d.scl = ~i2c_m | sy[SY_CTRL_CLOCK];
    s_d.sda_i = ~i2c_m | sy[SY_SDA];
    s_d.sda_o = 1'b0;
    s_d.sda_oe_n = ~(i2c_m & sda_pull_low_in);

    // Watchdog on master clock edges.
    s_d.mclk_prev = sy[SY_MCLK];
    if (mclk_rise) begin
      s_d.idle = '0;
      s_d.mcnt = RATIO_W'(s_q.mcnt + 1'b1);
    end else if (s_q.idle != STOP_CYC) begin
      s_d.idle = IDLE_W'(s_q.idle + 1'b1);
    end

    // Supervisor: absent, relocking, running.
    case (s_q.mc)
      MC_ABSENT: begin
        s_d.lockc = '0;
        if (mclk_rise) begin
          s_d.mc = MC_LOCKING;
        end
      end
      MC_LOCKING: begin
        if (s_q.idle == STOP_CYC) begin
          s_d.mc = MC_ABSENT;
        end else if (s_q.lockc == LOCK_CNT) begin
          s_d.mc = MC_RUN;
        end else if (mclk_rise) begin
          s_d.lockc = LOCK_W'(s_q.lockc + 1'b1);
        end
      end
      MC_RUN: begin
        if (s_q.idle == STOP_CYC) begin
          s_d.mc = MC_ABSENT;
        end
      end
      default: begin
        s_d.mc = MC_ABSENT;
      end
    endcase
    s_d.absent = (s_d.mc == MC_ABSENT);

    // Divider setting: measured per frame, or programmed for one-bit.
    if (s_q.mode == AIMPS_ONEBIT) begin
      s_d.div = RATIO_W'(stream_mclk_freq_field_in);
    end else if (rose(s_q.fclk_prev, fclk)) begin
      s_d.ratio = s_q.mcnt;
      s_d.div = s_q.mcnt;
      s_d.mcnt = '0;
    end

    // Hand pending lanes to the FIFO, one per accepted cycle.
    if (fifo_ready && s_q.pend != '0) begin
      s_d.pend[lane_sel] = 1'b0;
    end

    // Deserialise on the selected bit clock.
    s_d.bclk_prev = bclk;
    s_d.fclk_prev = fclk;
    if (running && bit_rise) begin
      for (int i = 0; i < LANES; i++) begin
        s_d.shf[i] = {s_q.shf[i][SW-2:0], lane_bit[i]};
      end
      if (s_q.mode == AIMPS_ONEBIT) begin
        s_d.bitcnt = CNT_W'(s_q.bitcnt + 1'b1);
        frame_edge = (s_q.bitcnt == LAST_BIT);
      end
    end

    // Frame boundary: channel clock either edge, word clock rising.
    if (running && s_q.mode == AIMPS_PCM) begin
      frame_edge = (fclk != s_q.fclk_prev);
    end else if (running && s_q.mode == AIMPS_EXF) begin
      frame_edge = rose(s_q.fclk_prev, fclk);
    end

    // Capture a finished word for every active lane.
    if (frame_edge) begin
      if (s_d.pend != '0) begin
        s_d.overrun = 1'b1;
      end
      s_d.hold = s_d.shf;
      s_d.side = s_q.fclk_prev;
      s_d.pend = (s_q.mode == AIMPS_PCM) ? PCM_LANES : ALL_LANES;
    end

    // Chain output re-sends the first lane, MSB first, on falling edges.
    if (!running || !s_q.chain_mode || s_q.mode != AIMPS_PCM) begin
      s_d.chain_o = 1'b0;
      s_d.chain = '0;
    end else if (frame_edge) begin
      s_d.chain = s_d.shf[0];
    end else if (bit_fall) begin
      s_d.chain_o = s_q.chain[SW-1];
      s_d.chain = {s_q.chain[SW-2:0], 1'b0};
    end

    // A quiet data path keeps nothing half captured.
    if (!running) begin
      s_d.pend = '0;
      s_d.bitcnt = '0;
    end
  end

  // Register the whole state; power-down acts as a synchronous reset.
  always_ff @(posedge clk_sys_in) begin
    if (run_rst) begin
      s_q <= '0;
      s_q.ctl_sel_n <= 1'b1;
      s_q.scl <= 1'b1;
      s_q.sda_i <= 1'b1;
      s_q.sda_oe_n <= 1'b1;
      s_q.absent <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Presented word: tag of side and lane, then the sample.
  assign fifo_valid = (s_q.pend != '0);
  assign fifo_data = {s_q.side, lane_sel, s_q.hold[lane_sel]};

  // Samples wait here until the consumer takes them.
  aimps_fifo #(
    .W(TAG_W + SW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(run_rst),
    .in_valid_in(fifo_valid),
    .in_data_in(fifo_data),
    .in_ready_out(fifo_ready),
    .out_valid_out(sample_valid_out),
    .out_data_out(sample_data_out),
    .out_ready_in(sample_ready_in)
  );

  // Outputs straight from the state register.
  assign reg_control_out = s_q.reg_mode;
  assign use_i2c_out = s_q.use_i2c;
  assign chip_addr_out = s_q.chip_addr;
  assign auto_clock_out = s_q.auto_clk;
  assign filter_select_c_out = s_q.filt_c;
  assign deemph_enable_out = s_q.deemph;
  assign frame_mode_out = s_q.frame_mode;
  assign chain_mode_out = s_q.chain_mode;
  assign right_invert_out = s_q.inv_r;
  assign input_mode_out = s_q.mode;
  assign ctrl_port_select_n_out = s_q.ctl_sel_n;
  assign ctrl_port_clock_out = s_q.ctl_clk;
  assign ctrl_port_data_out = s_q.ctl_dat;
  assign i2c_scl_out = s_q.scl;
  assign i2c_data_out = s_q.sda_i;
  assign i2c_sda_out = s_q.sda_o;
  assign i2c_sda_oe_n_out = s_q.sda_oe_n;
  assign mclk_absent_out = s_q.absent;
  assign mclk_div_out = s_q.div;
  assign overrun_out = s_q.overrun;
  assign chain_serial_out = s_q.chain_o;
endmodule

// ==== src/aimps_pkg.sv ====
// Constants shared by the audio input mode and pin select front end.
// Assumes a single 200 MHz system clock; every pin arrives asynchronously.
package aimps_pkg;
  // System clock rate and master clock watchdog.
  localparam int SYS_CLK_MHZ = 200;
  localparam int MCLK_STOP_NS = 1000;
  localparam int MCLK_STOP_CYC = (MCLK_STOP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LOCK_EDGES = 16;
  localparam int IDLE_W = 16;
  localparam int LOCK_W = 5;
  // Data path shape.
  localparam int SAMPLE_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 2;
  localparam int TAG_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int RATIO_W = 12;
  localparam int FIELD_W = 3;
  localparam logic [LANES-1:0] PCM_LANES = 4'h3;
  localparam logic [LANES-1:0] ALL_LANES = 4'hF;
  // Positions of the pins inside the synchroniser vector.
  localparam int SY_PDN = 0;
  localparam int SY_PSN = 1;
  localparam int SY_I2C = 2;
  localparam int SY_CLOCK_SETTING_SELECT = 3;
  localparam int SY_CHIP_ADDR_BIT0 = 4;
  localparam int SY_P43 = 5;
  localparam int SY_DAT = 6;
  localparam int SY_P48 = 10;
  localparam int SY_ALT = 11;
  localparam int SY_MCLK = 16;
  localparam int SY_CSN = 17;
  localparam int SY_CTRL_CLOCK = 18;
  localparam int SY_CTRL_DATA_IN = 19;
  localparam int SY_SDA = 20;
  localparam int NSYNC = 21;
  // Offsets inside the alternate pin group.
  localparam int ALT_DEEMPH = 0;
  localparam int ALT_CLK = 1;
  localparam int ALT_FRM1 = 2;
  localparam int ALT_CHAIN = 3;
  localparam int ALT_INV = 4;
  localparam int ALT_N = 5;
  // Input modes.
  typedef enum logic [1:0] {
    AIMPS_PCM = 2'h0,
    AIMPS_ONEBIT = 2'h1,
    AIMPS_EXF = 2'h3
  } aimps_mode_t;
  // Master clock supervisor states, Gray coded.
  typedef enum logic [1:0] {
    MC_ABSENT = 2'h0,
    MC_LOCKING = 2'h1,
    MC_RUN = 2'h3
  } aimps_mc_t;
endpackage

// ==== src/aimps_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes the pins change slowly against the system clock.
`timescale 1ns/1ps
module aimps_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } aimps_sync_t;
  aimps_sync_t s_q;
  aimps_sync_t s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  // Register both stages.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;
endmodule

// ==== src/aimps_fifo.sv ====
// Sample FIFO with a registered output stage.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
module aimps_fifo #(
  parameter int W = 35,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Filling side.
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side.
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
    logic ov;
    logic [W-1:0] od;
  } aimps_fifo_t;
  aimps_fifo_t s_q;
  aimps_fifo_t s_d;
  logic push;
  logic load;

  // Write, prefetch into the output stage and keep the count.
  always_comb begin
    s_d = s_q;
    push = in_valid_in & ~s_q.full;
    if (s_q.ov && out_ready_in) begin
      s_d.ov = 1'b0;
    end
    if (push) begin
      s_d.mem[s_q.wp] = in_data_in;
      s_d.wp = PW'(s_q.wp + 1'b1);
    end
    load = ~s_d.ov & (s_q.cnt != '0);
    if (load) begin
      s_d.od = s_q.mem[s_q.rp];
      s_d.ov = 1'b1;
      s_d.rp = PW'(s_q.rp + 1'b1);
    end
    s_d.cnt = CW'(s_q.cnt + CW'(push) - CW'(load));
    s_d.full = (s_d.cnt == FULL_CNT);
  end

  // Register the whole state.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready_out = ~s_q.full;
  assign out_valid_out = s_q.ov;
  assign out_data_out = s_q.od;
endmodule

// ==== verif/aimps_checker_assertions.sv ====
// Concurrent checks on the mode and pin select front end.
// Assumes it is bound into aimps_top and sees only that module's ports.
`timescale 1ns/1ps
module aimps_checker
  import aimps_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Watched inputs.
  input wire logic power_down_n_in,
  input wire logic control_style_select_in,
  input wire logic i2c_select_in,
  input wire logic clock_setting_select_in,
  input wire logic chip_addr_bit0_in,
  input wire logic mclk_in,
  input wire logic [1:0] input_mode_sel_in,
  input wire logic [FIELD_W-1:0] stream_mclk_freq_field_in,
  // Watched outputs.
  input wire logic reg_control_out,
  input wire logic use_i2c_out,
  input wire logic [1:0] chip_addr_out,
  input wire logic [1:0] input_mode_out,
  input wire logic mclk_absent_out,
  input wire logic [RATIO_W-1:0] mclk_div_out,
  input wire logic chain_mode_out,
  input wire logic chain_serial_out,
  input wire logic i2c_sda_oe_n_out,
  input wire logic sample_valid_out
);
  typedef struct packed {
    logic [7:0] idle;
    logic mclk;
  } aimps_chk_t;
  aimps_chk_t st_q;
  aimps_chk_t st_d;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  // Counts system clocks since the master clock pin last moved.
  always_comb begin
    st_d = st_q;
    st_d.mclk = mclk_in;
    if (mclk_in != st_q.mclk) begin
      st_d.idle = 8'h00;
    end else if (st_q.idle != 8'hFF) begin
      st_d.idle = st_q.idle + 8'h01;
    end
  end

  // Registers the helper state.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Pins held long enough to cross the synchronisers.
  sequence reg_steady;
    (power_down_n_in && !control_style_select_in)[*8];
  endsequence
  sequence pin_steady;
    (power_down_n_in && control_style_select_in)[*8];
  endsequence

  style_reg_a: assert property (reg_steady |-> reg_control_out)
    else $error("register control not decoded");
  style_pin_a: assert property (pin_steady |->
    !reg_control_out && input_mode_out == 2'h0)
    else $error("pin control not decoded");
  port_pick_a: assert property ((reg_steady and
    $stable(i2c_select_in)[*8]) |-> use_i2c_out == i2c_select_in)
    else $error("control port choice wrong");
  chip_addr_a: assert property ((reg_steady and
    $stable({clock_setting_select_in, chip_addr_bit0_in})[*8]) |->
    chip_addr_out == {clock_setting_select_in, chip_addr_bit0_in})
    else $error("chip address wrong");
  div_field_a: assert property ((reg_steady and (input_mode_sel_in == 2'h1
    && $stable(stream_mclk_freq_field_in))[*8]) |->
    mclk_div_out == RATIO_W'(stream_mclk_freq_field_in))
    else $error("divider not taken from field");
  pdn_hold_a: assert property ((!power_down_n_in)[*6] |->
    mclk_absent_out && !reg_control_out && !sample_valid_out)
    else $error("power-down did not hold reset");
  mclk_stop_a: assert property (st_q.idle == 8'hDC |-> mclk_absent_out)
    else $error("stopped master clock not flagged");
  quiet_a: assert property ((mclk_absent_out && !sample_valid_out)[*8]
    |=> !sample_valid_out)
    else $error("samples while master clock absent");
  chain_idle_a: assert property ((!chain_mode_out)[*2] |->
    !chain_serial_out)
    else $error("chain output active outside chain mode");
  sda_drive_a: assert property (!i2c_sda_oe_n_out |-> use_i2c_out)
    else $error("SDA driven outside I2C mode");
endmodule

bind aimps_top aimps_checker #(.SW(SW)) u_chk (.*);

// ==== verif/aimps_src.sv ====
// Behavioural audio source driving the master clock and PCM pins.
// Assumes the bench calls send_frame and gates the master clock.
`timescale 1ns/1ps
module aimps_src (
  // Master clock gate.
  input wire logic mclk_en_in,
  // Pins towards the front end.
  output logic mclk_out,
  output logic bit_clock_out,
  output logic [3:0] data_out
);
  // Master clock of 24 ns, two periods per bit clock period.
  initial begin
    mclk_out = 1'h0;
    bit_clock_out = 1'h0;
    data_out = 4'h5;
    forever begin
      #12;
      mclk_out = mclk_en_in ? ~mclk_out : 1'h0;
    end
  end

  // Sends one word on data lanes 0 and 2, MSB first, then flips the channel
  // clock; the bit clock rests low between words.
  task automatic send_frame(input logic [31:0] a, input logic [31:0] b);
    for (int i = 31; i >= 0; i--) begin
      data_out[0] = a[i];
      data_out[2] = b[i];
      data_out[3] = ~data_out[3];
      #24 bit_clock_out = 1'h1;
      #24 bit_clock_out = 1'h0;
    end
    // Released lanes show the inverse of their last bit.
    data_out[0] = ~a[0];
    data_out[2] = ~b[0];
    #12 data_out[1] = ~data_out[1];
    #24;
  endtask
endmodule

// ==== verif/aimps_top_tb.sv ====
// Self-checking bench for the mode and pin select front end.
// Assumes the checker is bound in and the source model drives audio pins.
`timescale 1ns/1ps
module aimps_top_tb
  import aimps_pkg::*;
();
  logic clk_sys_in, rst_in, power_down_n_in, control_style_select_in;
  logic i2c_select_in, clock_setting_select_in, chip_addr_bit0_in;
  logic word_clock_in, ctrl_select_n_in, ctrl_clock_in, ctrl_data_in;
  logic i2c_sda_in, stream_path_select_in, chain_enable_in, mclk_in;
  logic sda_pull_low_in, sample_ready_in, shared_clock_in, sda_drv, mclk_en;
  logic i2c_sda_out, i2c_sda_oe_n_out, reg_control_out, use_i2c_out;
  logic auto_clock_out, filter_select_c_out, deemph_enable_out;
  logic chain_mode_out, right_invert_out, ctrl_port_select_n_out;
  logic ctrl_port_clock_out, ctrl_port_data_out, i2c_scl_out;
  logic i2c_data_out, mclk_absent_out, overrun_out, chain_serial_out;
  logic sample_valid_out;
  logic [ALT_N-1:0] alt_group_in;
  logic [LANES-1:0] shared_data_in;
  logic [1:0] input_mode_sel_in, chip_addr_out, frame_mode_out;
  logic [1:0] input_mode_out;
  logic [FIELD_W-1:0] stream_mclk_freq_field_in;
  logic [RATIO_W-1:0] mclk_div_out;
  logic [TAG_W+SAMPLE_W-1:0] sample_data_out;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] chain_sh;
  localparam logic [31:0] ONEBIT_WORD = 32'hC33C_5AA5;

  // SDA wire: follows sda_drv, low whenever the front end enables its driver.
  assign i2c_sda_in = i2c_sda_oe_n_out ? sda_drv : 1'h0;

  aimps_top #(.SW(SAMPLE_W), .DEPTH(FIFO_DEPTH)) dut (.*);

  aimps_src u_src (
    .mclk_en_in(mclk_en),
    .mclk_out(mclk_in),
    .bit_clock_out(shared_clock_in),
    .data_out(shared_data_in)
  );

  // System clock of 5 ns.
  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // Cuts a hung run short.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] %0t run timed out", $time);
      close_out();
    end
  end

  // Collects the chain output at each rising bit clock.
  always @(posedge shared_clock_in) begin
    chain_sh <= {chain_sh[30:0], chain_serial_out};
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic cmp(input logic [34:0] got, input logic [34:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Waits for a sample, compares it and takes it with one ready cycle.
  task automatic get_word(input logic [34:0] exp);
    int n;
    n = 0;
    while (sample_valid_out !== 1'h1 && n < 400) begin
      tick(1);
      n++;
    end
    cmp(sample_data_out, exp, "sample");
    sample_ready_in = 1'h1;
    tick(1);
    sample_ready_in = 1'h0;
    tick(1);
  endtask

  // Powers down around a change of control style.
  task automatic set_style(input logic s);
    power_down_n_in = 1'h0;
    tick(8);
    control_style_select_in = s;
    tick(2);
    power_down_n_in = 1'h1;
    tick(10);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_in = 1'h1;
    power_down_n_in = 1'h0;
    control_style_select_in = 1'h0;
    i2c_select_in = 1'h0;
    clock_setting_select_in = 1'h0;
    chip_addr_bit0_in = 1'h0;
    word_clock_in = 1'h0;
    ctrl_select_n_in = 1'h1;
    ctrl_clock_in = 1'h0;
    ctrl_data_in = 1'h0;
    stream_path_select_in = 1'h0;
    chain_enable_in = 1'h0;
    sda_pull_low_in = 1'h0;
    sample_ready_in = 1'h0;
    sda_drv = 1'h1;
    mclk_en = 1'h0;
    alt_group_in = 5'h00;
    input_mode_sel_in = 2'h0;
    stream_mclk_freq_field_in = 3'h0;
    tick(10);
    rst_in = 1'h0;
    tick(3);
    cmp(35'({mclk_absent_out, ctrl_port_select_n_out, reg_control_out}),
        35'h6, "pdn");
    power_down_n_in = 1'h1;
    tick(10);
    $display("%0t reset test done", $time);
    // Register control: 3-wire then I2C, with the address pins swapped.
    ctrl_select_n_in = 1'h0;
    ctrl_clock_in = 1'h1;
    ctrl_data_in = 1'h1;
    sda_drv = 1'h0;
    for (int i = 0; i < 2; i++) begin
      i2c_select_in = i[0];
      clock_setting_select_in = i[0];
      chip_addr_bit0_in = ~i[0];
      tick(4);
      sda_pull_low_in = i[0];
      tick(8);
      cmp(35'({reg_control_out, use_i2c_out, chip_addr_out}),
          35'({1'h1, i[0], i[0], ~i[0]}), "decode");
      cmp(35'({ctrl_port_select_n_out, ctrl_port_clock_out,
          ctrl_port_data_out, i2c_scl_out, i2c_data_out, i2c_sda_oe_n_out}),
          i[0] ? 35'h24 : 35'h1F, "port");
    end
    sda_pull_low_in = 1'h0;
    tick(4);
    $display("%0t control port test done", $time);
    // Every input mode code, the field mirrored in one-bit mode.
    stream_mclk_freq_field_in = 3'h5;
    for (int m = 0; m < 4; m++) begin
      input_mode_sel_in = m[1:0];
      tick(10);
      cmp(35'(input_mode_out), (m == 2) ? 35'h0 : 35'(m), "mode");
      if (m == 1) cmp(35'(mclk_div_out), 35'h5, "div");
    end
    input_mode_sel_in = 2'h0;
    $display("%0t mode test done", $time);
    // Two PCM frames, four words, captured while the sink stalls, then drained.
    mclk_en = 1'h1;
    chain_enable_in = 1'h1;
    tick(150);
    cmp(35'(mclk_absent_out), 35'h0, "lock");
    u_src.send_frame(32'hA5C3_0F81, 32'h1234_5678);
    u_src.send_frame(32'h8000_0001, 32'hFEDC_BA98);
    cmp(35'(chain_sh), 35'(32'hA5C3_0F81 >> 1), "chain");
    tick(1);
    get_word({3'h0, 32'hA5C3_0F81});
    get_word({3'h1, 32'h1234_5678});
    get_word({3'h4, 32'h8000_0001});
    get_word({3'h5, 32'hFEDC_BA98});
    cmp(35'({overrun_out, sample_valid_out}), 35'h0, "overrun");
    $display("%0t capture test done", $time);
    // One-bit stream on the alternate pins, word on lane 0 only.
    input_mode_sel_in = 2'h1;
    tick(4);
    for (int i = 31; i >= 0; i--) begin
      alt_group_in[ALT_DEEMPH] = ONEBIT_WORD[i];
      #24 alt_group_in[ALT_CLK] = 1'h1;
      #24 alt_group_in[ALT_CLK] = 1'h0;
    end
    tick(1);
    get_word({3'h0, ONEBIT_WORD});
    get_word({3'h1, 32'h0});
    get_word({3'h2, 32'h0});
    get_word({3'h3, 32'h0});
    alt_group_in = 5'h00;
    input_mode_sel_in = 2'h0;
    $display("%0t one-bit test done", $time);
    // Master clock stops: flagged absent and capture goes quiet.
    mclk_en = 1'h0;
    tick(300);
    cmp(35'(mclk_absent_out), 35'h1, "stop");
    u_src.send_frame(32'h0F0F_0F0F, 32'hF0F0_F0F0);
    tick(20);
    cmp(35'(sample_valid_out), 35'h0, "quiet");
    $display("%0t clock stop test done", $time);
    // Pin control: dual-purpose pins followed as static levels.
    set_style(1'h1);
    input_mode_sel_in = 2'h3;
    clock_setting_select_in = 1'h1;
    word_clock_in = 1'h1;
    alt_group_in = 5'h16;
    tick(10);
    cmp(35'({reg_control_out, auto_clock_out, filter_select_c_out}),
        35'h3, "pinctl");
    cmp(35'({deemph_enable_out, frame_mode_out, chain_mode_out,
        right_invert_out, input_mode_out}), 35'h34, "alt a");
    alt_group_in = 5'h09;
    tick(10);
    cmp(35'({deemph_enable_out, frame_mode_out, chain_mode_out,
        right_invert_out, input_mode_out}), 35'h48, "alt b");
    $display("%0t pin control test done", $time);
    close_out();
  end
endmodule
